// ==== design/gpsr_regs.sv ====
// Contract
// - first buffered set is applied only while the bank-select pin is low.
// - sync scale is 10-bit unsigned, lsb 1/256, low byte at 0x17.
// - sync scale top two bits from 0x1D bits 1-0, msb weighs 2.
// - luma gain is 10-bit, lsb 1/256, low byte at 0x18.
// - luma gain top two bits from 0x1B bits 7-6, msb weighs 2.
// - U gain is 11-bit, lsb 1/256, low byte at 0x19.
// - U gain top three bits from 0x1B bits 5-3, msb weighs 4.
// - V gain is 10-bit, lsb 1/256, low byte at 0x1A.
// - V gain top two bits from 0x1B bits 1-0, msb weighs 2.
// - 9-bit luma/RGB offset: low byte 0x1C, top bit 0x1D bit 2.
// - phase offset is 15 bits; bits 6-0 from 0x1E bits 7-1.
// - phase offset bits 14-7 from register 0x1F.
// - 0x1E bit 0 high inverts the V axis sign.
// - subcarrier seed is 28 bits; bits 3-0 from 0x20 bits 7-4.
// - seed bits 11-4 from register 0x21.
// - seed bits 19-12 from register 0x22.
// - seed bits 27-20 from register 0x23, the top byte.
`timescale 1ns/100ps
`include "gpsr_defs.svh"

module gpsr_regs (
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   // control port pins
   input  wire logic                       ctl_cs_n,
   input  wire logic                       ctl_wr_n,
   input  wire logic                       ctl_rd_n,
   input  wire logic [`GPSR_ADDR_W-1:0]    ctl_addr,
   input  wire logic [7:0]                 ctl_data_in,
   output      logic [7:0]                 ctl_data_out,
   output      logic                       ctl_data_oe,
   // bank select pin, low picks set 0
   input  wire logic                       buffer_sel,
   // parameters to the datapath
   output      logic                       set0_active,
   output      logic [9:0]                 sync_scale_factor,
   output      logic [9:0]                 luma_gain,
   output      logic [10:0]                u_chroma_gain,
   output      logic [9:0]                 v_chroma_gain,
   output      logic [8:0]                 luma_rgb_offset,
   output      logic [14:0]                system_phase_offset,
   output      logic                       v_sign_flip,
   output      logic [27:0]                subcarrier_seed
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic                      cs_n_s1_q;
   logic                      cs_n_s2_q;
   logic                      wr_n_s1_q;
   logic                      wr_n_s2_q;
   logic                      wr_n_s3_q;
   logic                      rd_n_s1_q;
   logic                      rd_n_s2_q;
   logic [`GPSR_ADDR_W-1:0]   addr_s1_q;
   logic [`GPSR_ADDR_W-1:0]   addr_s2_q;
   logic [7:0]                data_s1_q;
   logic [7:0]                data_s2_q;
   logic                      bsel_s1_q;
   logic                      bsel_s2_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cs_n_s1_q <= 1'b1;
         cs_n_s2_q <= 1'b1;
         wr_n_s1_q <= 1'b1;
         wr_n_s2_q <= 1'b1;
         wr_n_s3_q <= 1'b1;
         rd_n_s1_q <= 1'b1;
         rd_n_s2_q <= 1'b1;
      end else begin
         cs_n_s1_q <= ctl_cs_n;
         cs_n_s2_q <= cs_n_s1_q;
         wr_n_s1_q <= ctl_wr_n;
         wr_n_s2_q <= wr_n_s1_q;
         wr_n_s3_q <= wr_n_s2_q;
         rd_n_s1_q <= ctl_rd_n;
         rd_n_s2_q <= rd_n_s1_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         addr_s1_q <= {`GPSR_ADDR_W{1'b0}};
         addr_s2_q <= {`GPSR_ADDR_W{1'b0}};
         data_s1_q <= `GPSR_IDLE_DATA;
         data_s2_q <= `GPSR_IDLE_DATA;
      end else begin
         addr_s1_q <= ctl_addr;
         addr_s2_q <= addr_s1_q;
         data_s1_q <= ctl_data_in;
         data_s2_q <= data_s1_q;
      end
   end

   // high at reset so set 1 is assumed until the pin is really seen low
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bsel_s1_q <= 1'b1;
         bsel_s2_q <= 1'b1;
      end else begin
         bsel_s1_q <= buffer_sel;
         bsel_s2_q <= bsel_s1_q;
      end
   end

   // ************************************************************
   // address decode
   // ************************************************************
   logic                      addr_hit;
   logic [`GPSR_ADDR_W-1:0]   addr_rel;
   logic [`GPSR_IDX_W-1:0]    reg_idx;

   always_comb begin
      addr_hit = (addr_s2_q >= `GPSR_FIRST_OFF) && (addr_s2_q <= `GPSR_LAST_OFF);
      addr_rel = addr_s2_q - `GPSR_FIRST_OFF;
      reg_idx  = addr_rel[`GPSR_IDX_W-1:0];
   end

   // ************************************************************
   // port sequencer
   // ************************************************************
   // writes commit at the rising edge of the strobe so data has settled
   gpsr_pkg::gpsr_port_state_t state_q;
   gpsr_pkg::gpsr_port_state_t state_d;
   logic                       wr_commit;
   logic                       rd_start;

   always_comb begin
      state_d   = state_q;
      wr_commit = 1'b0;
      rd_start  = 1'b0;
      case (state_q)
         gpsr_pkg::GPSR_PORT_IDLE: begin
            if (!cs_n_s2_q && !wr_n_s2_q) begin
               state_d = gpsr_pkg::GPSR_PORT_WRITE;
            end else if (!cs_n_s2_q && !rd_n_s2_q) begin
               state_d  = gpsr_pkg::GPSR_PORT_READ;
               rd_start = addr_hit;
            end
         end
         gpsr_pkg::GPSR_PORT_WRITE: begin
            if (wr_n_s2_q && !wr_n_s3_q) begin
               wr_commit = addr_hit;
               state_d   = gpsr_pkg::GPSR_PORT_IDLE;
            end
         end
         gpsr_pkg::GPSR_PORT_READ: begin
            if (rd_n_s2_q || cs_n_s2_q) begin
               state_d = gpsr_pkg::GPSR_PORT_IDLE;
            end
         end
         default: begin
            state_d = gpsr_pkg::GPSR_PORT_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= gpsr_pkg::GPSR_PORT_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // register storage and readback
   // ************************************************************
   // reserved bits are stored as written; software keeps them zero
   gpsr_pkg::gpsr_byte_t           rd_byte;
   logic [8*`GPSR_NUM_REGS-1:0]    bank;

   gpsr_reg_mem u_mem (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .wr_en    (wr_commit),
      .wr_idx   (reg_idx),
      .wr_data  (data_s2_q),
      .rd_en    (rd_start),
      .rd_idx   (reg_idx),
      .rd_data  (rd_byte),
      .contents (bank)
   );

   // drive the shared bus only for our own addresses
   logic read_hit_q;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         read_hit_q <= 1'b0;
      end else if (rd_start) begin
         read_hit_q <= 1'b1;
      end else if (state_q != gpsr_pkg::GPSR_PORT_READ) begin
         read_hit_q <= 1'b0;
      end
   end

   assign ctl_data_out = rd_byte;
   assign ctl_data_oe  = read_hit_q && (state_q == gpsr_pkg::GPSR_PORT_READ);

   // ************************************************************
   // field assembly
   // ************************************************************
   gpsr_pkg::gpsr_byte_t r_sync_lo;
   gpsr_pkg::gpsr_byte_t r_luma_lo;
   gpsr_pkg::gpsr_byte_t r_u_lo;
   gpsr_pkg::gpsr_byte_t r_v_lo;
   gpsr_pkg::gpsr_byte_t r_gain_hi;
   gpsr_pkg::gpsr_byte_t r_offs_lo;
   gpsr_pkg::gpsr_byte_t r_offs_hi;
   gpsr_pkg::gpsr_byte_t r_phase_lo;
   gpsr_pkg::gpsr_byte_t r_phase_hi;
   gpsr_pkg::gpsr_byte_t r_seed_0;
   gpsr_pkg::gpsr_byte_t r_seed_1;
   gpsr_pkg::gpsr_byte_t r_seed_2;
   gpsr_pkg::gpsr_byte_t r_seed_3;

   always_comb begin
      r_sync_lo  = bank[8*(`GPSR_OFF_SYNC_SCALE_LOW - `GPSR_FIRST_OFF) +: 8];
      r_luma_lo  = bank[8*(`GPSR_OFF_LUMA_GAIN_LOW - `GPSR_FIRST_OFF) +: 8];
      r_u_lo     = bank[8*(`GPSR_OFF_U_GAIN_LOW - `GPSR_FIRST_OFF) +: 8];
      r_v_lo     = bank[8*(`GPSR_OFF_V_GAIN_LOW - `GPSR_FIRST_OFF) +: 8];
      r_gain_hi  = bank[8*(`GPSR_OFF_GAIN_HIGH_BITS - `GPSR_FIRST_OFF) +: 8];
      r_offs_lo  = bank[8*(`GPSR_OFF_LUMA_OFFSET_LOW - `GPSR_FIRST_OFF) +: 8];
      r_offs_hi  = bank[8*(`GPSR_OFF_OFFSET_SYNC_HIGH_BITS - `GPSR_FIRST_OFF) +: 8];
      r_phase_lo = bank[8*(`GPSR_OFF_PHASE_LOW_AND_FLIP - `GPSR_FIRST_OFF) +: 8];
      r_phase_hi = bank[8*(`GPSR_OFF_PHASE_HIGH - `GPSR_FIRST_OFF) +: 8];
      r_seed_0   = bank[8*(`GPSR_OFF_SEED_NIBBLE - `GPSR_FIRST_OFF) +: 8];
      r_seed_1   = bank[8*(`GPSR_OFF_SEED_LOWER_BYTE - `GPSR_FIRST_OFF) +: 8];
      r_seed_2   = bank[8*(`GPSR_OFF_SEED_MIDDLE_BYTE - `GPSR_FIRST_OFF) +: 8];
      r_seed_3   = bank[8*(`GPSR_OFF_SEED_TOP_BYTE - `GPSR_FIRST_OFF) +: 8];
   end

   logic [9:0]  sync_d;
   logic [9:0]  luma_d;
   logic [10:0] ugain_d;
   logic [9:0]  vgain_d;
   logic [8:0]  offs_d;
   logic [14:0] phase_d;
   logic        vflip_d;
   logic [27:0] seed_d;

   always_comb begin
      sync_d  = {r_offs_hi[`GPSR_SYNC_HI_MSB:`GPSR_SYNC_HI_LSB], r_sync_lo};
      luma_d  = {r_gain_hi[`GPSR_LUMA_HI_MSB:`GPSR_LUMA_HI_LSB], r_luma_lo};
      ugain_d = {r_gain_hi[`GPSR_U_HI_MSB:`GPSR_U_HI_LSB], r_u_lo};
      vgain_d = {r_gain_hi[`GPSR_V_HI_MSB:`GPSR_V_HI_LSB], r_v_lo};
      offs_d  = {r_offs_hi[`GPSR_OFFS_HI_BIT], r_offs_lo};
      phase_d = {r_phase_hi, r_phase_lo[`GPSR_PHASE_LO_MSB:`GPSR_PHASE_LO_LSB]};
      vflip_d = r_phase_lo[`GPSR_VFLIP_BIT];
      seed_d  = {r_seed_3, r_seed_2, r_seed_1,
                 r_seed_0[`GPSR_SEED_LO_MSB:`GPSR_SEED_LO_LSB]};
   end

   // ************************************************************
   // buffered set 0 outputs
   // ************************************************************
   // held while set 1 is selected, so writes made then never reach the datapath as a half-updated set
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         set0_active <= 1'b0;
      end else begin
         set0_active <= !bsel_s2_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sync_scale_factor   <= 10'h000;
         luma_gain           <= 10'h000;
         u_chroma_gain       <= 11'h000;
         v_chroma_gain       <= 10'h000;
         luma_rgb_offset     <= 9'h000;
         system_phase_offset <= 15'h0000;
         v_sign_flip         <= 1'b0;
      end else if (!bsel_s2_q) begin
         sync_scale_factor   <= sync_d;
         luma_gain           <= luma_d;
         u_chroma_gain       <= ugain_d;
         v_chroma_gain       <= vgain_d;
         luma_rgb_offset     <= offs_d;
         system_phase_offset <= phase_d;
         v_sign_flip         <= vflip_d;
      end
   end

   // seed is not part of the buffered set
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         subcarrier_seed <= 28'h000_0000;
      end else begin
         subcarrier_seed <= seed_d;
      end
   end

endmodule : gpsr_regs

// ==== common/gpsr_defs.svh ====
`ifndef GPSR_DEFS_SVH
`define GPSR_DEFS_SVH

// ************************************************************
// register offsets on the control port
// ************************************************************
`define GPSR_OFF_SYNC_SCALE_LOW        6'h17
`define GPSR_OFF_LUMA_GAIN_LOW         6'h18
`define GPSR_OFF_U_GAIN_LOW            6'h19
`define GPSR_OFF_V_GAIN_LOW            6'h1a
`define GPSR_OFF_GAIN_HIGH_BITS        6'h1b
`define GPSR_OFF_LUMA_OFFSET_LOW       6'h1c
`define GPSR_OFF_OFFSET_SYNC_HIGH_BITS 6'h1d
`define GPSR_OFF_PHASE_LOW_AND_FLIP    6'h1e
`define GPSR_OFF_PHASE_HIGH            6'h1f
`define GPSR_OFF_SEED_NIBBLE           6'h20
`define GPSR_OFF_SEED_LOWER_BYTE       6'h21
`define GPSR_OFF_SEED_MIDDLE_BYTE      6'h22
`define GPSR_OFF_SEED_TOP_BYTE         6'h23

// ************************************************************
// bank geometry and reset values
// ************************************************************
`define GPSR_ADDR_W      6
`define GPSR_IDX_W       4
`define GPSR_NUM_REGS    13
`define GPSR_FIRST_OFF   6'h17
`define GPSR_LAST_OFF    6'h23
`define GPSR_REG_RESET   8'h00
`define GPSR_IDLE_DATA   8'h00

// ************************************************************
// field positions
// ************************************************************
`define GPSR_LUMA_HI_MSB   7
`define GPSR_LUMA_HI_LSB   6
`define GPSR_U_HI_MSB      5
`define GPSR_U_HI_LSB      3
`define GPSR_V_HI_MSB      1
`define GPSR_V_HI_LSB      0
`define GPSR_OFFS_HI_BIT   2
`define GPSR_SYNC_HI_MSB   1
`define GPSR_SYNC_HI_LSB   0
`define GPSR_PHASE_LO_MSB  7
`define GPSR_PHASE_LO_LSB  1
`define GPSR_VFLIP_BIT     0
`define GPSR_SEED_LO_MSB   7
`define GPSR_SEED_LO_LSB   4

`endif

// ==== common/gpsr_pkg.sv ====
package gpsr_pkg;

   typedef logic [7:0] gpsr_byte_t;

   typedef enum logic [1:0] {
      GPSR_PORT_IDLE  = 2'b00,
      GPSR_PORT_WRITE = 2'b01,
      GPSR_PORT_READ  = 2'b10
   } gpsr_port_state_t;

endpackage : gpsr_pkg

// ==== design/gpsr_reg_mem.sv ====
`timescale 1ns/100ps
`include "gpsr_defs.svh"

module gpsr_reg_mem (
   input  wire logic                           core_clk,
   input  wire logic                           reset_n,
   input  wire logic                           wr_en,
   input  wire logic [`GPSR_IDX_W-1:0]         wr_idx,
   input  wire gpsr_pkg::gpsr_byte_t           wr_data,
   input  wire logic                           rd_en,
   input  wire logic [`GPSR_IDX_W-1:0]         rd_idx,
   output      gpsr_pkg::gpsr_byte_t           rd_data,
   output      logic [8*`GPSR_NUM_REGS-1:0]    contents
);

   gpsr_pkg::gpsr_byte_t mem_q [`GPSR_NUM_REGS];
   gpsr_pkg::gpsr_byte_t rd_data_q;

   // ************************************************************
   // storage, one byte per entry
   // ************************************************************
   genvar i;
   generate
      for (i = 0; i < `GPSR_NUM_REGS; i = i + 1) begin : g_entry
         always_ff @(posedge core_clk) begin
            if (!reset_n) begin
               mem_q[i] <= `GPSR_REG_RESET;
            end else if (wr_en && (wr_idx == i[`GPSR_IDX_W-1:0])) begin
               mem_q[i] <= wr_data;
            end
         end
         assign contents[8*i +: 8] = mem_q[i];
      end
   endgenerate

   // ************************************************************
   // registered read port
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rd_data_q <= `GPSR_IDLE_DATA;
      end else if (rd_en) begin
         if (rd_idx < `GPSR_NUM_REGS) begin
            rd_data_q <= mem_q[rd_idx];
         end else begin
            rd_data_q <= `GPSR_IDLE_DATA;
         end
      end
   end

   assign rd_data = rd_data_q;

endmodule : gpsr_reg_mem

// ==== sim/gpsr_regs_monitor.sv ====
`timescale 1ns/100ps
module gpsr_regs_monitor (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        ctl_rd_n,
   input wire logic [5:0]  ctl_addr,
   input wire logic [7:0]  ctl_data_out,
   input wire logic        ctl_data_oe,
   input wire logic        buffer_sel,
   input wire logic        set0_active,
   input wire logic [9:0]  sync_scale_factor,
   input wire logic [9:0]  luma_gain,
   input wire logic [10:0] u_chroma_gain,
   input wire logic [9:0]  v_chroma_gain,
   input wire logic [8:0]  luma_rgb_offset,
   input wire logic [14:0] system_phase_offset,
   input wire logic        v_sign_flip,
   input wire logic [27:0] subcarrier_seed
);
   logic set0_prev_q;
   logic rd_ok;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   always_ff @(posedge core_clk) begin
      set0_prev_q <= set0_active;
   end
   // fields lag the registers a cycle, so only trust them once set 0 has settled
   assign rd_ok = ctl_data_oe & set0_active & set0_prev_q;

   // ****************************************
   // selection and read port
   // ****************************************
   property p_set0_on; (!buffer_sel)[*4] |=> set0_active; endproperty
   a_set0_on: assert property (p_set0_on) else $error("set 0 not applied");
   property p_set0_off; buffer_sel[*4] |=> !set0_active; endproperty
   a_set0_off: assert property (p_set0_off) else $error("set 0 still applied");
   property p_hold; !set0_active && !$past(set0_active) |-> $stable({sync_scale_factor,
      luma_gain, u_chroma_gain, v_chroma_gain, luma_rgb_offset, system_phase_offset,
      v_sign_flip}); endproperty
   a_hold: assert property (p_hold) else $error("set 0 moved while deselected");
   property p_oe_hit; ctl_data_oe |-> ctl_addr inside {[6'h17:6'h23]}; endproperty
   a_oe_hit: assert property (p_oe_hit) else $error("drive on foreign address");
   property p_oe_drop; ctl_rd_n[*5] |=> !ctl_data_oe; endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("data pins held too long");

   // ****************************************
   // readback against field outputs
   // ****************************************
   property p_sync; rd_ok && ctl_addr == 6'h17 |-> ctl_data_out == sync_scale_factor[7:0];
   endproperty
   a_sync: assert property (p_sync) else $error("sync scale low mismatch");
   property p_gain_lo; rd_ok && ctl_addr inside {6'h18, 6'h19, 6'h1a} |-> ctl_data_out ==
      (ctl_addr == 6'h18 ? luma_gain[7:0] : ctl_addr == 6'h19 ? u_chroma_gain[7:0] :
      v_chroma_gain[7:0]); endproperty
   a_gain_lo: assert property (p_gain_lo) else $error("gain low mismatch");
   property p_gain_hi; rd_ok && ctl_addr == 6'h1b |-> {ctl_data_out[7:3], ctl_data_out[1:0]}
      == {luma_gain[9:8], u_chroma_gain[10:8], v_chroma_gain[9:8]}; endproperty
   a_gain_hi: assert property (p_gain_hi) else $error("gain high mismatch");
   property p_offs; rd_ok && ctl_addr == 6'h1c |-> ctl_data_out == luma_rgb_offset[7:0];
   endproperty
   a_offs: assert property (p_offs) else $error("offset low mismatch");
   property p_hi1d; rd_ok && ctl_addr == 6'h1d |-> ctl_data_out[2:0] ==
      {luma_rgb_offset[8], sync_scale_factor[9:8]}; endproperty
   a_hi1d: assert property (p_hi1d) else $error("offset or sync top mismatch");
   property p_phase; rd_ok && ctl_addr == 6'h1e |-> ctl_data_out ==
      {system_phase_offset[6:0], v_sign_flip}; endproperty
   a_phase: assert property (p_phase) else $error("phase low or flip mismatch");
   property p_phase_hi; rd_ok && ctl_addr == 6'h1f |-> ctl_data_out ==
      system_phase_offset[14:7]; endproperty
   a_phase_hi: assert property (p_phase_hi) else $error("phase high mismatch");
   property p_seed_nib; ctl_data_oe && ctl_addr == 6'h20 |-> ctl_data_out[7:4] ==
      subcarrier_seed[3:0]; endproperty
   a_seed_nib: assert property (p_seed_nib) else $error("seed nibble mismatch");
   property p_seed; ctl_data_oe && ctl_addr inside {[6'h21:6'h23]} |-> ctl_data_out ==
      subcarrier_seed[4 + 8 * (ctl_addr - 6'h21) +: 8]; endproperty
   a_seed: assert property (p_seed) else $error("seed byte mismatch");
endmodule : gpsr_regs_monitor

// ==== sim/gpsr_regs_tb.sv ====
`timescale 1ns/100ps
module gpsr_regs_tb;
   logic        core_clk, reset_n, ctl_cs_n, ctl_wr_n, ctl_rd_n, buffer_sel;
   logic [5:0]  ctl_addr;
   logic [7:0]  ctl_data_in, ctl_data_out;
   logic        ctl_data_oe, set0_active, v_sign_flip;
   logic [9:0]  sync_scale_factor, luma_gain, v_chroma_gain;
   logic [10:0] u_chroma_gain;
   logic [8:0]  luma_rgb_offset;
   logic [14:0] system_phase_offset;
   logic [27:0] subcarrier_seed;
   int          fail_count, checks_done;
   logic [7:0]  mem [13];
   logic [7:0]  held [13];
   logic [7:0]  tab [13] = '{8'ha5, 8'h3c, 8'h96, 8'h5a, 8'he3, 8'hc7, 8'h06, 8'hb5, 8'h81,
                             8'hd0, 8'h2b, 8'he4, 8'h7f};
   // reserved bits must go out as zero
   logic [7:0]  msk [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, 8'hff, 8'h07, 8'hff, 8'hff,
                             8'hf0, 8'hff, 8'hff, 8'hff};

   gpsr_regs i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .ctl_cs_n(ctl_cs_n), .ctl_wr_n(ctl_wr_n),
      .ctl_rd_n(ctl_rd_n), .ctl_addr(ctl_addr), .ctl_data_in(ctl_data_in),
      .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe), .buffer_sel(buffer_sel),
      .set0_active(set0_active), .sync_scale_factor(sync_scale_factor),
      .luma_gain(luma_gain), .u_chroma_gain(u_chroma_gain), .v_chroma_gain(v_chroma_gain),
      .luma_rgb_offset(luma_rgb_offset), .system_phase_offset(system_phase_offset),
      .v_sign_flip(v_sign_flip), .subcarrier_seed(subcarrier_seed)
   );

   // ****************************************
   // checking and port tasks
   // ****************************************
   task finish_test;
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test

   task chk(input string name, input logic [27:0] got, input logic [27:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // pins pass two synchronisers, so each phase but the single edge between strobe and select release is held several edges
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      ctl_cs_n <= 1'b0; ctl_wr_n <= 1'b0; ctl_addr <= a; ctl_data_in <= d;
      repeat (4) @(posedge core_clk);
      ctl_wr_n <= 1'b1;
      @(posedge core_clk);
      ctl_cs_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (a >= 6'h17 && a <= 6'h23) mem[a - 6'h17] = d;
   endtask : wr

   task rd(input logic [5:0] a, input logic hit);
      logic got;
      @(posedge core_clk);
      ctl_cs_n <= 1'b0; ctl_rd_n <= 1'b0; ctl_addr <= a;
      got = 1'b0;
      for (int n = 0; n < 10 && !got; n++) begin
         @(posedge core_clk);
         got = (ctl_data_oe === 1'b1);
      end
      ctl_cs_n <= 1'b1; ctl_rd_n <= 1'b1;
      chk("read drive", 28'(got), 28'(hit));
      if (got && hit) chk("read data", 28'(ctl_data_out), 28'(mem[a - 6'h17]));
      for (int n = 0; n < 10 && ctl_data_oe !== 1'b0; n++) @(posedge core_clk);
      chk("read release", 28'(ctl_data_oe), 28'h000_0000);
      if (ctl_data_oe !== 1'b0) finish_test();
      repeat (3) @(posedge core_clk);
   endtask : rd

   task rd_all;
      for (int i = 0; i < 13; i++) rd(6'h17 + 6'(i), 1'b1);
   endtask : rd_all

   task check_out;
      chk("sync", 28'(sync_scale_factor), 28'({held[6][1:0], held[0]}));
      chk("luma", 28'(luma_gain), 28'({held[4][7:6], held[1]}));
      chk("u gain", 28'(u_chroma_gain), 28'({held[4][5:3], held[2]}));
      chk("v gain", 28'(v_chroma_gain), 28'({held[4][1:0], held[3]}));
      chk("offset", 28'(luma_rgb_offset), 28'({held[6][2], held[5]}));
      chk("phase", 28'(system_phase_offset), 28'({held[8], held[7][7:1]}));
      chk("flip", 28'(v_sign_flip), 28'(held[7][0]));
      chk("seed", subcarrier_seed,
          {mem[12], mem[11], mem[10], mem[9][7:4]});
   endtask : check_out

   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      reset_n = 1'b0; ctl_cs_n = 1'b1; ctl_wr_n = 1'b1; ctl_rd_n = 1'b1; buffer_sel = 1'b0;
      ctl_addr = 6'h00; ctl_data_in = 8'h00; fail_count = 0; checks_done = 0;
      foreach (mem[i]) mem[i] = 8'h00;
      held = mem;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_all();
      check_out();
      for (int i = 0; i < 13; i++) wr(6'h17 + 6'(i), tab[i]);
      repeat (4) @(posedge core_clk);
      held = mem;
      check_out();
      rd_all();
      buffer_sel <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("set0 active", 28'(set0_active), 28'h000_0000);
      for (int i = 0; i < 13; i++) wr(6'h17 + 6'(i), ~tab[i] & msk[i]);
      repeat (4) @(posedge core_clk);
      check_out();
      rd_all();
      buffer_sel <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("set0 active", 28'(set0_active), 28'h000_0001);
      held = mem;
      check_out();
      // stray writes around the bank must not alias onto its edges
      wr(6'h16, 8'h5a);
      wr(6'h24, 8'ha5);
      rd(6'h16, 1'b0);
      rd(6'h24, 1'b0);
      rd_all();
      finish_test();
   end
endmodule : gpsr_regs_tb

bind gpsr_regs gpsr_regs_monitor i_mon (
   .core_clk(core_clk), .reset_n(reset_n), .ctl_rd_n(ctl_rd_n), .ctl_addr(ctl_addr),
   .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe), .buffer_sel(buffer_sel),
   .set0_active(set0_active), .sync_scale_factor(sync_scale_factor), .luma_gain(luma_gain),
   .u_chroma_gain(u_chroma_gain), .v_chroma_gain(v_chroma_gain),
   .luma_rgb_offset(luma_rgb_offset), .system_phase_offset(system_phase_offset),
   .v_sign_flip(v_sign_flip), .subcarrier_seed(subcarrier_seed)
);
